// ===== core/dog_pkg.sv
package dog_pkg;

	// timing
	localparam int CLOCK_HZ = 25_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int MS_PER_S = 1_000;
	localparam int DEBOUNCE_TIME_US = 30;
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_US * CLOCK_HZ + US_PER_S - 1) / US_PER_S;
	localparam int MS_TIME = 1;
	localparam int MS_CYCLES = MS_TIME * CLOCK_HZ / MS_PER_S;
	localparam int DEB_W = 12;
	localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYCLES - 1);
	localparam int TICK_W = 24;
	localparam logic [7:0] RESET_HOLD_CYCLES = 8'h10;

	//////////////////////////////////////////////////////////////////////////////
	// register map: printed offset kept as index, byte address is four times it
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] INDEX_CAUSE = 12'h0b1;
	localparam logic [ADDR_W-1:0] INDEX_EVENT_STATUS = 12'h0b2;
	localparam logic [ADDR_W-1:0] INDEX_EVENT_MASK = 12'h0b3;
	localparam logic [ADDR_W-1:0] ADDR_CAUSE = {INDEX_CAUSE[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = {INDEX_EVENT_STATUS[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = {INDEX_EVENT_MASK[ADDR_W-3:0], 2'b00};

	// cause register fields
	localparam int BIT_DOG_OVERFLOW = 7;
	localparam int BIT_POWER_ON = 5;
	localparam int BIT_LOW_VOLTAGE = 4;
	localparam int BIT_PIN_RESET = 3;
	localparam int PERIOD_MSB = 2;
	localparam logic [2:0] PERIOD_RESET = 3'h0;
	localparam logic [7:0] CAUSE_RESET_VALUE = 8'h20;

	// event status and mask layout
	localparam int EVENT_COUNT = 4;
	localparam int EV_DOG = 0;
	localparam int EV_RANGE = 1;
	localparam int EV_LOW = 2;
	localparam int EV_PIN = 3;

	// minimum overflow period in milliseconds per select code
	localparam int PERIOD_W = 13;
	localparam logic [PERIOD_W-1:0] PERIOD_MS [8] = '{13'h1000, 13'h0400, 13'h0100, 13'h0080,
		13'h0040, 13'h0010, 13'h0004, 13'h0001};

	localparam logic [7:0] ILLEGAL_OPCODE = 8'ha5;
	localparam int PC_W = 16;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SEQ_RUN = 2'b00,
		SEQ_HOLD = 2'b01
	} seq_state_e;

endpackage

// ===== core/supply_debounce.sv
`timescale 1ns/10ps
module supply_debounce
	import dog_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	supply_if.filter sup
);
	logic state_reg;
	logic state_next;
	logic [DEB_W-1:0] count_reg;
	logic [DEB_W-1:0] count_next;

	// a level that disagrees with the filtered state must hold unbroken for the full
	// debounce time; any return resets the count, so short dips are swallowed
	always_comb
	begin
		state_next = state_reg;
		count_next = '0;
		if (!sup.enable)
		begin
			state_next = 1'b0;
		end
		else if (sup.supply_low != state_reg)
		begin
			if (count_reg == DEB_LAST)
			begin
				state_next = sup.supply_low;
			end
			else
			begin
				count_next = count_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= 1'b0;
			count_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	assign sup.reset_active = state_reg;
endmodule

// ===== core/supply_if.sv
`timescale 1ns/10ps
interface supply_if;
	logic supply_low;
	logic enable;
	logic reset_active;
	modport filter (input supply_low, input enable, output reset_active);
	modport owner (output supply_low, output enable, input reset_active);
endinterface

// ===== core/watchdog_and_reset_status.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module watchdog_and_reset_status
	import dog_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = MS_CYCLES,
	parameter logic [PC_W:0] PROGRAM_WORDS = 17'h1_0000
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic watchdog_enable_option,
	input wire logic undervoltage_enable_option,
	input wire logic supply_low,
	input wire logic pin_reset_n,
	input wire logic fetch_valid,
	input wire logic [PC_W-1:0] fetch_pc,
	input wire logic [7:0] fetch_opcode,
	output logic cpu_reset,
	output logic device_reset,
	output logic irq,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	//////////////////////////////////////////////////////////////////////////////
	// low-voltage filter

	supply_if sup ();
	assign sup.supply_low = supply_low;
	assign sup.enable = undervoltage_enable_option;

	supply_debounce u_debounce (
		.clock(clock),
		.rst(rst),
		.sup(sup)
	);

	//////////////////////////////////////////////////////////////////////////////
	// register bus state

	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic aw_have_reg, aw_have_next;
	logic [7:0] wdata_reg, wdata_next;
	logic wlane_reg, wlane_next;
	logic w_have_reg, w_have_next;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;

	logic do_write;
	logic do_read;
	logic wr_cause;
	logic wr_status;
	logic wr_mask;
	logic touch_cause;

	// block state
	logic [7:0] cause_reg, cause_next;
	logic [EVENT_COUNT-1:0] status_reg, status_next;
	logic [EVENT_COUNT-1:0] mask_reg, mask_next;
	logic [TICK_W-1:0] tick_reg, tick_next;
	logic [PERIOD_W-1:0] ms_left_reg, ms_left_next;
	seq_state_e seq_reg, seq_next;
	logic [7:0] hold_reg, hold_next;
	logic full_reg, full_next;
	logic pin_low_reg, pin_low_next;
	logic low_v_reg, low_v_next;
	logic cpu_reset_reg, cpu_reset_next;
	logic device_reset_reg, device_reset_next;
	logic irq_reg, irq_next;

	logic dog_overflow;
	logic range_fault;
	logic pin_event;
	logic low_event;
	logic any_event;
	logic [EVENT_COUNT-1:0] events;

	//////////////////////////////////////////////////////////////////////////////
	// bus slave: address and data taken in either order; read answer one cycle later, write answer two cycles after the last of them

	assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
	assign do_read = s_axi_arvalid && arready_reg;
	assign wr_cause = do_write && awaddr_reg == ADDR_CAUSE && wlane_reg;
	assign wr_status = do_write && awaddr_reg == ADDR_EVENT_STATUS && wlane_reg;
	assign wr_mask = do_write && awaddr_reg == ADDR_EVENT_MASK && wlane_reg;
	// the restart counts the access itself, whatever lanes it strobes
	assign touch_cause = (do_write && awaddr_reg == ADDR_CAUSE)
		|| (do_read && s_axi_araddr == ADDR_CAUSE);

	always_comb
	begin
		awaddr_next = awaddr_reg;
		aw_have_next = aw_have_reg;
		wdata_next = wdata_reg;
		wlane_next = wlane_reg;
		w_have_next = w_have_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && awready_reg)
		begin
			awaddr_next = s_axi_awaddr;
			aw_have_next = 1'b1;
		end
		if (s_axi_wvalid && wready_reg)
		begin
			wdata_next = s_axi_wdata[7:0];
			wlane_next = s_axi_wstrb[0];
			w_have_next = 1'b1;
		end
		if (do_write)
		begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			if (awaddr_reg == ADDR_CAUSE || awaddr_reg == ADDR_EVENT_STATUS
				|| awaddr_reg == ADDR_EVENT_MASK)
				bresp_next = RESP_OKAY;
			else
				bresp_next = RESP_SLVERR;
		end
		else if (bvalid_reg && s_axi_bready)
		begin
			bvalid_next = 1'b0;
		end
		awready_next = !aw_have_next && !bvalid_next;
		wready_next = !w_have_next && !bvalid_next;
	end

	always_comb
	begin
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (do_read)
		begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CAUSE: rdata_next = {24'h00_0000, cause_reg};
				ADDR_EVENT_STATUS: rdata_next = {28'h000_0000, status_reg};
				ADDR_EVENT_MASK: rdata_next = {28'h000_0000, mask_reg};
				default:
				begin
					rdata_next = 32'h0000_0000;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	//////////////////////////////////////////////////////////////////////////////
	// reset sources

	assign range_fault = fetch_valid
		&& ({1'b0, fetch_pc} >= PROGRAM_WORDS
		|| fetch_opcode == ILLEGAL_OPCODE);
	// the debug clock stands in for the free-running oscillator and is never gated here,
	// so the count keeps going whatever power state the core is in
	assign dog_overflow = watchdog_enable_option && seq_reg == SEQ_RUN
		&& ms_left_reg == '0 && tick_reg == '0;
	assign pin_low_next = !pin_reset_n;
	assign low_v_next = sup.reset_active;
	assign pin_event = pin_low_next && !pin_low_reg;
	assign low_event = low_v_next && !low_v_reg;
	assign any_event = dog_overflow || range_fault || pin_low_next || low_v_next;

	always_comb
	begin
		events = '0;
		events[EV_DOG] = dog_overflow;
		events[EV_RANGE] = range_fault;
		events[EV_LOW] = low_event;
		events[EV_PIN] = pin_event;
	end

	// hold the reset outputs for a fixed stretch after the last active source
	always_comb
	begin
		seq_next = seq_reg;
		hold_next = hold_reg;
		full_next = full_reg;
		if (any_event)
		begin
			seq_next = SEQ_HOLD;
			hold_next = RESET_HOLD_CYCLES;
			// an out-of-range fault alone touches the core, not the whole device
			if (seq_reg == SEQ_RUN)
				full_next = dog_overflow || pin_low_next || low_v_next;
			else
				full_next = full_reg || dog_overflow || pin_low_next || low_v_next;
		end
		else if (seq_reg == SEQ_HOLD)
		begin
			if (hold_reg == 8'h00)
			begin
				seq_next = SEQ_RUN;
				full_next = 1'b0;
			end
			else
			begin
				hold_next = hold_reg - 1'b1;
			end
		end
		cpu_reset_next = seq_next == SEQ_HOLD;
		device_reset_next = seq_next == SEQ_HOLD && full_next;
	end

	//////////////////////////////////////////////////////////////////////////////
	// cause register: hardware sets win over a software clear in the same cycle

	always_comb
	begin
		cause_next = cause_reg;
		if (wr_cause)
		begin
			// a written one leaves a flag as it was; only zero clears
			cause_next[BIT_DOG_OVERFLOW] = cause_reg[BIT_DOG_OVERFLOW]
				& wdata_reg[BIT_DOG_OVERFLOW];
			cause_next[BIT_POWER_ON] = cause_reg[BIT_POWER_ON] & wdata_reg[BIT_POWER_ON];
			cause_next[BIT_LOW_VOLTAGE] = cause_reg[BIT_LOW_VOLTAGE]
				& wdata_reg[BIT_LOW_VOLTAGE];
			cause_next[BIT_PIN_RESET] = cause_reg[BIT_PIN_RESET] & wdata_reg[BIT_PIN_RESET];
			cause_next[PERIOD_MSB:0] = wdata_reg[PERIOD_MSB:0];
		end
		if (dog_overflow || range_fault)
			cause_next[BIT_DOG_OVERFLOW] = 1'b1;
		if (low_v_next)
			cause_next[BIT_LOW_VOLTAGE] = 1'b1;
		if (pin_low_next)
			cause_next[BIT_PIN_RESET] = 1'b1;
		if (any_event || seq_reg == SEQ_HOLD)
			cause_next[PERIOD_MSB:0] = PERIOD_RESET;
		cause_next[6] = 1'b0;
	end

	//////////////////////////////////////////////////////////////////////////////
	// watchdog down counter: milliseconds from a tick prescaler

	always_comb
	begin
		tick_next = tick_reg;
		ms_left_next = ms_left_reg;
		if (touch_cause || any_event || seq_reg == SEQ_HOLD || !watchdog_enable_option)
		begin
			tick_next = TICK_LAST;
			ms_left_next = PERIOD_MS[cause_next[PERIOD_MSB:0]] - 1'b1;
		end
		else if (tick_reg == '0)
		begin
			tick_next = TICK_LAST;
			ms_left_next = ms_left_reg - 1'b1;
		end
		else
		begin
			tick_next = tick_reg - 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// event status, mask and interrupt

	always_comb
	begin
		status_next = status_reg;
		mask_next = mask_reg;
		if (wr_status)
			status_next = status_reg & ~wdata_reg[EVENT_COUNT-1:0];
		if (wr_mask)
			mask_next = wdata_reg[EVENT_COUNT-1:0];
		status_next = status_next | events;
		irq_next = |(status_next & mask_next);
	end

	//////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			awaddr_reg <= '0;
			aw_have_reg <= 1'b0;
			wdata_reg <= 8'h00;
			wlane_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			cause_reg <= CAUSE_RESET_VALUE;
			status_reg <= '0;
			mask_reg <= '0;
			tick_reg <= TICK_LAST;
			ms_left_reg <= PERIOD_MS[PERIOD_RESET] - 1'b1;
			seq_reg <= SEQ_RUN;
			hold_reg <= 8'h00;
			full_reg <= 1'b0;
			pin_low_reg <= 1'b0;
			low_v_reg <= 1'b0;
			cpu_reset_reg <= 1'b0;
			device_reset_reg <= 1'b0;
			irq_reg <= 1'b0;
		end
		else
		begin
			awaddr_reg <= awaddr_next;
			aw_have_reg <= aw_have_next;
			wdata_reg <= wdata_next;
			wlane_reg <= wlane_next;
			w_have_reg <= w_have_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			cause_reg <= cause_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			tick_reg <= tick_next;
			ms_left_reg <= ms_left_next;
			seq_reg <= seq_next;
			hold_reg <= hold_next;
			full_reg <= full_next;
			pin_low_reg <= pin_low_next;
			low_v_reg <= low_v_next;
			cpu_reset_reg <= cpu_reset_next;
			device_reset_reg <= device_reset_next;
			irq_reg <= irq_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign cpu_reset = cpu_reset_reg;
	assign device_reset = device_reset_reg;
	assign irq = irq_reg;
endmodule

// ===== testbench/watchdog_and_reset_status_monitor.sv
`timescale 1ns/10ps
module watchdog_and_reset_status_monitor
	import dog_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = MS_CYCLES,
	parameter logic [PC_W:0] PROGRAM_WORDS = 17'h1_0000
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic undervoltage_enable_option,
	input wire logic supply_low,
	input wire logic pin_reset_n,
	input wire logic fetch_valid,
	input wire logic [PC_W-1:0] fetch_pc,
	input wire logic [7:0] fetch_opcode,
	input wire logic cpu_reset,
	input wire logic device_reset,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// saturates so a long brown-out cannot wrap back into the window
	logic [DEB_W-1:0] low_run_reg;
	logic [DEB_W-1:0] low_run_next;

	always_comb
	begin
		low_run_next = low_run_reg;
		if (!(supply_low && undervoltage_enable_option))
			low_run_next = '0;
		else if (low_run_reg != 12'hfff)
			low_run_next = low_run_reg + 12'h001;
	end

	always_ff @(posedge clock or posedge rst)
		if (rst)
			low_run_reg <= '0;
		else
			low_run_reg <= low_run_next;

	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_ILLEGAL_OPCODE: assert property (
		fetch_valid && fetch_opcode == ILLEGAL_OPCODE |-> ##[1:3] cpu_reset)
		else $error("no cpu reset after illegal opcode");
	AST_PC_RANGE: assert property (
		fetch_valid && {1'b0, fetch_pc} >= PROGRAM_WORDS |-> ##[1:3] cpu_reset)
		else $error("no cpu reset after pc range fault");
	AST_PIN_RESET: assert property (!pin_reset_n |-> ##[1:3] device_reset)
		else $error("no device reset from pin");
	AST_RESET_STRETCH: assert property ($rose(pin_reset_n) |-> ##2 cpu_reset [*8])
		else $error("reset released too early");
	AST_LOW_DEBOUNCE: assert property (low_run_reg == DEB_LAST + 12'h006 |-> device_reset)
		else $error("no reset after long supply low");
	AST_READ_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RDATA_HOLD: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	AST_BRESP_HOLD: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");

	cover property (!pin_reset_n ##3 device_reset);
	cover property (fetch_valid && fetch_opcode == ILLEGAL_OPCODE ##2 cpu_reset);
	cover property (low_run_reg == DEB_LAST);
endmodule

bind watchdog_and_reset_status watchdog_and_reset_status_monitor #(
	.TICK_CYCLES(TICK_CYCLES),
	.PROGRAM_WORDS(PROGRAM_WORDS)
) monitor (
	.clock(clock), .rst(rst), .undervoltage_enable_option(undervoltage_enable_option),
	.supply_low(supply_low), .pin_reset_n(pin_reset_n), .fetch_valid(fetch_valid),
	.fetch_pc(fetch_pc), .fetch_opcode(fetch_opcode), .cpu_reset(cpu_reset),
	.device_reset(device_reset), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

// ===== testbench/watchdog_and_reset_status_tb.sv
`timescale 1ns/10ps
module watchdog_and_reset_status_tb
	import dog_pkg::*;
;
	// short tick keeps the longest tested period at 16384 cycles
	localparam int TICK = 4;
	localparam int LIMIT = 40000;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic watchdog_enable_option = 1'b1;
	logic undervoltage_enable_option = 1'b1;
	logic supply_low = 1'b0;
	logic pin_reset_n = 1'b1;
	logic fetch_valid = 1'b0;
	logic [PC_W-1:0] fetch_pc = 16'h0000;
	logic [7:0] fetch_opcode = 8'h00;
	logic [ADDR_W-1:0] s_axi_awaddr = 12'h000;
	logic [ADDR_W-1:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic cpu_reset, device_reset, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata;
	logic [7:0] d;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;

	watchdog_and_reset_status #(.TICK_CYCLES(TICK), .PROGRAM_WORDS(17'h0_4000)) dut (
		.clock(clock), .rst(rst), .watchdog_enable_option(watchdog_enable_option),
		.undervoltage_enable_option(undervoltage_enable_option), .supply_low(supply_low),
		.pin_reset_n(pin_reset_n), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
		.fetch_opcode(fetch_opcode), .cpu_reset(cpu_reset), .device_reset(device_reset),
		.irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);

	always #20 clock = ~clock;

	////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// ready is read before the edge's own updates land, so each channel drops on its own edge
	task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		logic aw_ok = 1'b0;
		logic w_ok = 1'b0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge clock);
			aw_ok = aw_ok || s_axi_awready;
			w_ok = w_ok || s_axi_wready;
			s_axi_awvalid <= !aw_ok;
			s_axi_wvalid <= !w_ok;
		end
		@(posedge clock);
		s_axi_bready <= 1'b1;
		do
			@(posedge clock);
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [ADDR_W-1:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
			@(posedge clock);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		@(posedge clock);
		s_axi_rready <= 1'b1;
		do
			@(posedge clock);
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic read_check(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] e);
		axi_read(a);
		check(what, d, e);
		check("resp", r, RESP_OKAY);
	endtask

	task automatic wait_dev(input logic want, input int limit);
		n = 0;
		while (device_reset !== want && n < limit)
		begin
			@(posedge clock);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////
	task automatic test_reset_values();
		read_check("cause", ADDR_CAUSE, CAUSE_RESET_VALUE);
		read_check("mask", ADDR_EVENT_MASK, 8'h00);
		axi_read(12'h000);
		check("unmapped", {r, d}, {RESP_SLVERR, 8'h00});
		axi_write(12'h000, 8'h00);
		check("unmapped write", r, RESP_SLVERR);
		axi_write(ADDR_CAUSE, 8'h21);
		check("write resp", r, RESP_OKAY);
		read_check("flag kept", ADDR_CAUSE, 8'h21);
		$display("reset value test done");
	endtask

	task automatic test_dog();
		int lim;
		watchdog_enable_option <= 1'b0;
		axi_write(ADDR_CAUSE, 8'h07);
		wait_dev(1'b1, 100);
		check("dog off", device_reset, 1'b0);
		watchdog_enable_option <= 1'b1;
		wait_dev(1'b1, 100);
		check("dog on", device_reset, 1'b1);
		for (int sel = 0; sel < 8; sel++)
		begin
			wait_dev(1'b0, 100);
			axi_write(ADDR_CAUSE, 8'(sel));
			lim = int'(PERIOD_MS[sel]) * TICK;
			wait_dev(1'b1, lim + 20);
			check("period", n + 5 >= lim && n <= lim + 5, 1'b1);
		end
		wait_dev(1'b0, 100);
		read_check("dog flag", ADDR_CAUSE, 8'h80);
		read_check("event", ADDR_EVENT_STATUS, 8'h01);
		check("irq masked", irq, 1'b0);
		axi_write(ADDR_EVENT_MASK, 8'h01);
		repeat (2) @(posedge clock);
		check("irq", irq, 1'b1);
		axi_write(ADDR_EVENT_STATUS, 8'h01);
		repeat (2) @(posedge clock);
		check("irq cleared", irq, 1'b0);
		$display("watchdog test done");
	endtask

	task automatic test_refresh();
		axi_write(ADDR_CAUSE, 8'h05);
		for (int i = 0; i < 6; i++)
		begin
			repeat (40) @(posedge clock);
			if (i % 2 == 1)
				axi_read(ADDR_CAUSE);
			else
				axi_write(ADDR_CAUSE, 8'h05);
		end
		// a write with lane 0 off changes nothing but still restarts the count
		s_axi_wstrb <= 4'h0;
		repeat (2)
		begin
			repeat (40) @(posedge clock);
			axi_write(ADDR_CAUSE, 8'h00);
		end
		s_axi_wstrb <= 4'h1;
		read_check("no overflow", ADDR_CAUSE, 8'h05);
		axi_write(ADDR_CAUSE, 8'h00);
		$display("refresh test done");
	endtask

	task automatic test_pin();
		pin_reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		pin_reset_n <= 1'b1;
		check("pin reset", device_reset, 1'b1);
		wait_dev(1'b0, 100);
		read_check("pin flag", ADDR_CAUSE, 8'h08);
		axi_write(ADDR_CAUSE, 8'h00);
		read_check("cleared", ADDR_CAUSE, 8'h00);
		$display("pin test done");
	endtask

	task automatic fetch(input logic [PC_W-1:0] pc, input logic [7:0] op, input logic e);
		@(posedge clock);
		fetch_valid <= 1'b1;
		fetch_pc <= pc;
		fetch_opcode <= op;
		@(posedge clock);
		fetch_valid <= 1'b0;
		repeat (2) @(posedge clock);
		check("cpu reset", cpu_reset, e);
		check("device reset", device_reset, 1'b0);
		repeat (30) @(posedge clock);
		read_check("range flag", ADDR_CAUSE, {e, 7'h00});
		axi_write(ADDR_CAUSE, 8'h00);
	endtask

	task automatic test_low();
		supply_low <= 1'b1;
		wait_dev(1'b1, DEBOUNCE_CYCLES - 50);
		supply_low <= 1'b0;
		wait_dev(1'b1, 800);
		check("short dip", device_reset, 1'b0);
		supply_low <= 1'b1;
		wait_dev(1'b1, 900);
		check("set", device_reset === 1'b1 && n >= DEBOUNCE_CYCLES - 1, 1'b1);
		supply_low <= 1'b0;
		wait_dev(1'b0, 900);
		check("release", n >= DEBOUNCE_CYCLES, 1'b1);
		read_check("low flag", ADDR_CAUSE, 8'h10);
		axi_write(ADDR_CAUSE, 8'h00);
		undervoltage_enable_option <= 1'b0;
		supply_low <= 1'b1;
		wait_dev(1'b1, 900);
		check("option off", device_reset, 1'b0);
		supply_low <= 1'b0;
		$display("low voltage test done");
	endtask

	// a second power-on reset mid-run must clear the pin flag and set the power-on flag
	task automatic test_power_on();
		pin_reset_n <= 1'b0;
		@(posedge clock);
		pin_reset_n <= 1'b1;
		wait_dev(1'b0, 100);
		read_check("pin before", ADDR_CAUSE, 8'h08);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		read_check("power on", ADDR_CAUSE, CAUSE_RESET_VALUE);
		$display("power on test done");
	endtask

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			miscompares++;
			final_report();
		end
	end

	initial
	begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		test_reset_values();
		test_dog();
		test_refresh();
		test_pin();
		fetch(16'h3fff, 8'h00, 1'b0);
		fetch(16'h4000, 8'h00, 1'b1);
		fetch(16'h0100, ILLEGAL_OPCODE, 1'b1);
		fetch(16'h0100, 8'ha4, 1'b0);
		$display("range test done");
		test_low();
		test_power_on();
		final_report();
	end
endmodule
